// ===== verilog/axhh_pkg.sv
// Purpose: shared constants for the axis home and hold block
// Assumes: registers reached over AHB-Lite, 32-bit words
// Notes: axis banks start at AX_BASE, one bank per axis
package axhh_pkg;
  // global register byte offsets
  localparam logic [11:0] A_CMD = 12'h000;
  localparam logic [11:0] A_MODE = 12'h004;
  localparam logic [11:0] A_IRQ_ST = 12'h008;
  localparam logic [11:0] A_IRQ_MSK = 12'h00C;
  localparam logic [11:0] A_REPORT_DB = 12'h010;
  localparam logic [11:0] A_QCOST = 12'h014;
  localparam logic [11:0] AX_BASE = 12'h040;
  // word index inside one axis bank
  localparam logic [2:0] R_HOME = 3'h0;
  localparam logic [2:0] R_DB = 3'h1;
  localparam logic [2:0] R_GAIN = 3'h2;
  localparam logic [2:0] R_VLIM = 3'h3;
  localparam logic [2:0] R_TGT = 3'h4;
  localparam logic [2:0] R_RAMP = 3'h5;
  localparam logic [2:0] R_STAT = 3'h6;
  localparam logic [2:0] R_AXCFG = 3'h7;
  // home pin bit order inside a 4-bit group
  localparam int HB_HOME = 0;
  localparam int HB_IDX = 1;
  localparam int HB_A = 2;
  localparam int HB_B = 3;
  // axis config bits
  localparam int CF_ENC = 0;
  localparam int CF_SERVO = 1;
  localparam int CF_APWR = 2;
  localparam int CF_SETTLE = 3;
  // reset and limits
  localparam logic [3:0] POL_RST = 4'h6;
  localparam logic [15:0] DB_RST = 16'h0000;
  localparam logic [15:0] DB_MAX = 16'hFA00;
  localparam logic [14:0] GAIN_RST = 15'h0001;
  localparam logic [14:0] GAIN_MIN = 15'h0001;
  localparam logic [14:0] GAIN_MAX = 15'h7D00;
  localparam logic [15:0] VLIM_RST = 16'hFFFF;
  // queue entry cost of a slip-monitored start
  localparam logic [7:0] QC_CMD_BASE = 8'h05;
  localparam logic [7:0] QC_ARG_BASE = 8'h00;
  localparam logic [7:0] QC_ENC_CMD = 8'h01;
  localparam logic [7:0] QC_ENC_ARG = 8'h02;
  localparam logic [7:0] QC_APWR_CMD = 8'h02;
  localparam logic [7:0] QC_SET_CMD = 8'h02;
  localparam logic [7:0] QC_SET_ARG = 8'h01;
  typedef enum logic [3:0] {
    OP_GO = 4'h1,
    OP_GO_SLIP = 4'h2,
    OP_GO_UNEQ = 4'h3,
    OP_HOLD_ON = 4'h4,
    OP_HOLD_OFF = 4'h5,
    OP_HOME_ENC = 4'h6,
    OP_HOME_SW = 4'h7
  } axhh_op_t;
endpackage

// ===== verilog/axhh_axis_if.sv
// Purpose: per-axis signals between core, home and hold logic
// Assumes: one instance per axis
// Notes: pins and pol use the HB_* bit order
`timescale 1ns/1ps
interface axhh_axis_if;
  logic signed [31:0] target;
  logic signed [31:0] pos;
  logic [15:0] deadband;
  logic [15:0] vlim;
  logic [14:0] gain;
  logic hold_en;
  logic in_pos;
  logic [15:0] vel;
  logic dir;
  logic [3:0] pins;
  logic [3:0] pol;
  logic enc_mode;
  logic home_true;
  logic switch_act;
  modport core(output target, pos, deadband, vlim, gain, hold_en, pins, pol, enc_mode,
    input in_pos, vel, dir, home_true, switch_act);
  modport hold(input target, pos, deadband, vlim, gain, hold_en, output in_pos, vel, dir);
  modport home(input pins, pol, enc_mode, output home_true, switch_act);
endinterface

// ===== verilog/axhh_home_detect.sv
// Purpose: home condition from switch and encoder signals
// Assumes: pins already synchronised
// Notes: purely combinational
`timescale 1ns/1ps
module axhh_home_detect (
  axhh_axis_if.home a
);
  import axhh_pkg::*;
  logic [3:0] match;
  // each signal compared with its programmed true level
  assign match = ~(a.pins ^ a.pol);
  assign a.switch_act = match[HB_HOME];
  // encoder mode ands all four, switch mode uses home only
  assign a.home_true = a.enc_mode ? (&match) : match[HB_HOME];
endmodule

// ===== verilog/axhh_hold_calc.sv
// Purpose: hold correction velocity for one axis
// Assumes: encoder position on the same clock
// Notes: purely combinational, result registered by the core
`timescale 1ns/1ps
module axhh_hold_calc (
  axhh_axis_if.hold a
);
  logic signed [32:0] err;
  logic [32:0] mag;
  logic [47:0] prod;
  assign err = {a.target[31], a.target} - {a.pos[31], a.pos};
  assign mag = err[32] ? 33'(-err) : 33'(err);
  assign a.in_pos = (mag <= {17'h00000, a.deadband});
  assign prod = 48'(mag) * 48'(a.gain);
  assign a.dir = err[32];
  always_comb begin
    if (!a.hold_en || a.in_pos) begin
      a.vel = 16'h0000;
    end else if (prod > {32'h00000000, a.vlim}) begin
      a.vel = a.vlim;
    end else begin
      a.vel = prod[15:0];
    end
  end
endmodule

// ===== verilog/axhh_core.sv
// Purpose: axis move starts, home detect, hold control, AHB-Lite slave
// Assumes: profile generator and encoder counters on hclk
// Notes: zero wait state slave, response always OKAY
`timescale 1ns/1ps
module axhh_core #(
  parameter int N = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [N-1:0] home_pin,
  input wire logic [N-1:0] index_pin,
  input wire logic [N-1:0] enc_a_pin,
  input wire logic [N-1:0] enc_b_pin,
  input wire logic [N-1:0][31:0] enc_pos,
  input wire logic [N-1:0] motion_busy,
  output logic [N-1:0] move_start,
  output logic [15:0] move_ramp_up,
  output logic [15:0] move_ramp_down,
  output logic [N-1:0] hold_enable,
  output logic [N-1:0] stall_enable,
  output logic [N-1:0] track_enable,
  output logic [N-1:0] loop_closed,
  output logic [N-1:0][15:0] hold_vel,
  output logic [N-1:0] hold_dir,
  output logic [N-1:0] in_position,
  output logic [N-1:0] home_detect,
  output logic irq
);
  import axhh_pkg::*;
  localparam int AW = (N > 1) ? $clog2(N) : 1;

  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] rdata;
    logic [N-1:0][3:0] s1;
    logic [N-1:0][3:0] s2;
    logic [AW-1:0] sel;
    logic multi;
    logic [N-1:0] slip;
    logic [N-1:0] mask;
    logic [N-1:0] arm;
    logic [N-1:0] busy_q;
    logic [N-1:0] enc_mode;
    logic [N-1:0][3:0] pol;
    logic [N-1:0][15:0] db;
    logic [N-1:0][14:0] gain;
    logic [N-1:0][15:0] vlim;
    logic [N-1:0][31:0] tgt;
    logic [N-1:0][15:0] up;
    logic [N-1:0][15:0] dn;
    logic [N-1:0][3:0] cfg;
    logic [N-1:0] hold;
    logic [N-1:0] stall;
    logic [N-1:0] track;
    logic [N-1:0] loopc;
    logic [N-1:0] start;
    logic [15:0] acc;
    logic [15:0] dec;
    logic [N-1:0][15:0] hvel;
    logic [N-1:0] hdir;
    logic [N-1:0] inpos;
    logic [N-1:0] home;
    logic irq;
  } axhh_state_t;

  axhh_state_t st_reg;
  axhh_state_t st_next;
  logic [N-1:0] in_pos_w;
  logic [N-1:0][15:0] vel_w;
  logic [N-1:0] dir_w;
  logic [N-1:0] home_w;
  logic [N-1:0] sw_w;

  ////////////////////////////////////////////////////////////////////////////
  // per-axis home and hold logic
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_ax
      axhh_axis_if ifc();
      assign ifc.target = st_reg.tgt[g];
      assign ifc.pos = enc_pos[g];
      assign ifc.deadband = st_reg.db[g];
      assign ifc.vlim = st_reg.vlim[g];
      assign ifc.gain = st_reg.gain[g];
      assign ifc.hold_en = st_reg.hold[g];
      assign ifc.pins = st_reg.s2[g];
      assign ifc.pol = st_reg.pol[g];
      assign ifc.enc_mode = st_reg.enc_mode[g];
      assign in_pos_w[g] = ifc.in_pos;
      assign vel_w[g] = ifc.vel;
      assign dir_w[g] = ifc.dir;
      assign home_w[g] = ifc.home_true;
      assign sw_w[g] = ifc.switch_act;
      axhh_home_detect u_home (.a(ifc));
      axhh_hold_calc u_hold (.a(ifc));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic acc_ok;
  logic [11:0] ra;
  logic [AW-1:0] rax;
  logic rax_ok;
  logic [AW-1:0] wax;
  logic wax_ok;
  logic wr_cmd;
  logic [3:0] op;
  logic [N-1:0] tmask;
  logic [15:0] wdb;
  logic [14:0] wgain;
  logic [7:0] qc_cmd;
  logic [7:0] qc_arg;
  logic [3:0] scfg;

  assign acc_ok = hsel && hready && htrans[1];
  assign ra = haddr[11:0];
  assign rax = AW'(ra[7:5] - 3'h2);
  assign rax_ok = (ra[11:8] == 4'h0) && (ra >= AX_BASE) && (32'(ra[7:5] - 3'h2) < N);
  assign wax = AW'(st_reg.addr[7:5] - 3'h2);
  assign wax_ok = (st_reg.addr[11:8] == 4'h0) && (st_reg.addr >= AX_BASE)
    && (32'(st_reg.addr[7:5] - 3'h2) < N);
  assign wr_cmd = st_reg.wr && (st_reg.addr == A_CMD);
  assign op = hwdata[3:0];
  // null (zero) mask bits leave an axis untouched
  assign tmask = st_reg.multi ? hwdata[8 +: N] : N'(1) << st_reg.sel;
  assign wdb = (hwdata > 32'(DB_MAX)) ? DB_MAX : hwdata[15:0];
  assign wgain = (hwdata[31:0] < 32'(GAIN_MIN)) ? GAIN_MIN
    : (hwdata[31:0] > 32'(GAIN_MAX)) ? GAIN_MAX : hwdata[14:0];
  assign scfg = st_reg.cfg[st_reg.sel];
  // queue cost of a slip-monitored start on the selected axis
  assign qc_cmd = QC_CMD_BASE + ((scfg[CF_ENC] || scfg[CF_SERVO]) ? QC_ENC_CMD : 8'h00)
    + (scfg[CF_APWR] ? QC_APWR_CMD : 8'h00) + (scfg[CF_SETTLE] ? QC_SET_CMD : 8'h00);
  assign qc_arg = QC_ARG_BASE + ((scfg[CF_ENC] || scfg[CF_SERVO]) ? QC_ENC_ARG : 8'h00)
    + (scfg[CF_SETTLE] ? QC_SET_ARG : 8'h00);

  always_comb begin
    st_next = st_reg;
    st_next.start = '0;
    st_next.s1 = {enc_b_pin, enc_a_pin, index_pin, home_pin};
    for (int i = 0; i < N; i++) begin
      st_next.s1[i] = {enc_b_pin[i], enc_a_pin[i], index_pin[i], home_pin[i]};
    end
    st_next.s2 = st_reg.s1;
    st_next.wr = acc_ok && hwrite;
    if (acc_ok) begin
      st_next.addr = ra;
    end
    // read data captured in the address phase
    if (acc_ok && !hwrite) begin
      st_next.rdata = 32'h00000000;
      if (ra == A_MODE) begin
        st_next.rdata = {23'h000000, st_reg.multi, 8'(st_reg.sel)};
      end else if (ra == A_IRQ_ST) begin
        st_next.rdata = 32'(st_reg.slip);
      end else if (ra == A_IRQ_MSK) begin
        st_next.rdata = 32'(st_reg.mask);
      end else if (ra == A_REPORT_DB) begin
        if (!st_reg.multi && scfg[CF_ENC] && !scfg[CF_SERVO]) begin
          st_next.rdata = {16'h0000, st_reg.db[st_reg.sel]};
        end
      end else if (ra == A_QCOST) begin
        st_next.rdata = {16'h0000, qc_arg, qc_cmd};
      end else if (rax_ok) begin
        if (ra[4:2] == R_HOME) begin
          st_next.rdata = {27'h0000000, st_reg.enc_mode[rax], st_reg.pol[rax]};
        end else if (ra[4:2] == R_DB) begin
          st_next.rdata = {16'h0000, st_reg.db[rax]};
        end else if (ra[4:2] == R_GAIN) begin
          st_next.rdata = {17'h00000, st_reg.gain[rax]};
        end else if (ra[4:2] == R_VLIM) begin
          st_next.rdata = {16'h0000, st_reg.vlim[rax]};
        end else if (ra[4:2] == R_TGT) begin
          st_next.rdata = st_reg.tgt[rax];
        end else if (ra[4:2] == R_RAMP) begin
          st_next.rdata = {st_reg.dn[rax], st_reg.up[rax]};
        end else if (ra[4:2] == R_STAT) begin
          st_next.rdata = {24'h000000, st_reg.loopc[rax], st_reg.track[rax],
            st_reg.stall[rax], st_reg.hold[rax], st_reg.busy_q[rax], st_reg.home[rax],
            st_reg.inpos[rax], st_reg.slip[rax]};
        end else begin
          st_next.rdata = {28'h0000000, st_reg.cfg[rax]};
        end
      end
    end
    // data-phase writes
    if (st_reg.wr) begin
      if (st_reg.addr == A_MODE) begin
        st_next.sel = hwdata[AW-1:0];
        st_next.multi = hwdata[8];
      end else if (st_reg.addr == A_IRQ_ST) begin
        st_next.slip = st_reg.slip & ~hwdata[N-1:0];
      end else if (st_reg.addr == A_IRQ_MSK) begin
        st_next.mask = hwdata[N-1:0];
      end else if (wax_ok) begin
        if (st_reg.addr[4:2] == R_HOME) begin
          st_next.pol[wax] = hwdata[3:0];
          st_next.enc_mode[wax] = hwdata[4];
        end else if (st_reg.addr[4:2] == R_DB) begin
          st_next.db[wax] = wdb;
        end else if (st_reg.addr[4:2] == R_GAIN) begin
          st_next.gain[wax] = wgain;
        end else if (st_reg.addr[4:2] == R_VLIM) begin
          st_next.vlim[wax] = hwdata[15:0];
        end else if (st_reg.addr[4:2] == R_TGT) begin
          st_next.tgt[wax] = hwdata;
        end else if (st_reg.addr[4:2] == R_RAMP) begin
          st_next.up[wax] = hwdata[15:0];
          st_next.dn[wax] = hwdata[31:16];
        end else if (st_reg.addr[4:2] == R_STAT) begin
          st_next.slip[wax] = st_reg.slip[wax] & ~hwdata[0];
        end else begin
          st_next.cfg[wax] = hwdata[3:0];
        end
      end
    end
    // commands
    for (int i = 0; i < N; i++) begin
      if (wr_cmd && tmask[i]) begin
        case (op)
          OP_GO: begin
            st_next.start[i] = 1'b1;
            st_next.acc = st_reg.up[i];
            st_next.dec = st_reg.up[i];
          end
          OP_GO_SLIP: begin
            if (!st_reg.multi) begin
              st_next.start[i] = 1'b1;
              st_next.arm[i] = 1'b1;
              st_next.acc = st_reg.up[i];
              st_next.dec = st_reg.up[i];
            end
          end
          OP_GO_UNEQ: begin
            if (!st_reg.multi) begin
              st_next.start[i] = 1'b1;
              st_next.acc = st_reg.up[i];
              st_next.dec = st_reg.dn[i];
            end
          end
          OP_HOLD_ON: begin
            if (st_reg.cfg[i][CF_SERVO]) begin
              st_next.loopc[i] = 1'b1;
            end else if (st_reg.cfg[i][CF_ENC]) begin
              st_next.hold[i] = 1'b1;
              st_next.stall[i] = 1'b1;
              st_next.track[i] = 1'b1;
            end
          end
          OP_HOLD_OFF: begin
            st_next.hold[i] = 1'b0;
            st_next.stall[i] = 1'b0;
            st_next.track[i] = 1'b0;
            st_next.loopc[i] = 1'b0;
          end
          OP_HOME_ENC: st_next.enc_mode[i] = 1'b1;
          OP_HOME_SW: st_next.enc_mode[i] = 1'b0;
          default: ;
        endcase
      end
    end
    // slip watch, hold results; set beats clear
    for (int i = 0; i < N; i++) begin
      st_next.busy_q[i] = motion_busy[i];
      if (st_reg.arm[i] && st_reg.busy_q[i] && !motion_busy[i]) begin
        st_next.arm[i] = 1'b0;
      end
      if (st_reg.arm[i] && sw_w[i]) begin
        st_next.slip[i] = 1'b1;
      end
      st_next.hvel[i] = vel_w[i];
      st_next.hdir[i] = dir_w[i];
      st_next.inpos[i] = in_pos_w[i];
      st_next.home[i] = home_w[i];
    end
    st_next.irq = |(st_next.slip & st_next.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      for (int i = 0; i < N; i++) begin
        st_reg.pol[i] <= POL_RST;
        st_reg.db[i] <= DB_RST;
        st_reg.gain[i] <= GAIN_RST;
        st_reg.vlim[i] <= VLIM_RST;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign move_start = st_reg.start;
  assign move_ramp_up = st_reg.acc;
  assign move_ramp_down = st_reg.dec;
  assign hold_enable = st_reg.hold;
  assign stall_enable = st_reg.stall;
  assign track_enable = st_reg.track;
  assign loop_closed = st_reg.loopc;
  assign hold_vel = st_reg.hvel;
  assign hold_dir = st_reg.hdir;
  assign in_position = st_reg.inpos;
  assign home_detect = st_reg.home;
  assign irq = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks on axis 0
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic clr0;
  assign clr0 = st_reg.wr && (st_reg.addr == A_IRQ_ST) && hwdata[0];
  property p_slip_set;
    st_reg.arm[0] && sw_w[0] |=> st_reg.slip[0] && (irq || !st_reg.mask[0]);
  endproperty
  a_slip_set: assert property (p_slip_set) else $error("slip not flagged");
  property p_uneq;
    wr_cmd && op == OP_GO_UNEQ && !st_reg.multi && tmask[0]
      |=> move_start[0] && move_ramp_down == $past(st_reg.dn[0]) ##1 !move_start[0];
  endproperty
  a_uneq: assert property (p_uneq) else $error("unequal start wrong");
  property p_inpos;
    in_position[0] |-> hold_vel[0] == 16'h0000;
  endproperty
  a_inpos: assert property (p_inpos) else $error("correction inside deadband");
  property p_db_max;
    st_reg.db[0] <= DB_MAX;
  endproperty
  a_db_max: assert property (p_db_max) else $error("deadband over limit");
  property p_vlim;
    hold_vel[0] <= $past(st_reg.vlim[0]);
  endproperty
  a_vlim: assert property (p_vlim) else $error("hold velocity over limit");
  property p_gain;
    st_reg.gain[0] >= GAIN_MIN && st_reg.gain[0] <= GAIN_MAX;
  endproperty
  a_gain: assert property (p_gain) else $error("gain out of range");
  property p_hold_off;
    wr_cmd && op == OP_HOLD_OFF && tmask[0] |=> !hold_enable[0] && !loop_closed[0];
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("hold off ignored");
  property p_null_arg;
    wr_cmd && st_reg.multi && !hwdata[8] |=> $stable(loop_closed[0]) && $stable(hold_enable[0]);
  endproperty
  a_null_arg: assert property (p_null_arg) else $error("null axis changed");
  property p_sticky;
    st_reg.slip[0] && !clr0 && !(wax_ok && wax == 0 && st_reg.addr[4:2] == R_STAT
      && st_reg.wr && hwdata[0]) |=> st_reg.slip[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("slip flag lost");
endmodule

// ===== test/axhh_plant.sv
// Purpose: profile generator stand-in, busy for a fixed time per start
// Assumes: move_start is a one-cycle pulse per axis
// Notes: MOVE_LEN sets move duration in cycles
`timescale 1ns/1ps
module axhh_plant #(
  parameter int N = 4,
  parameter int MOVE_LEN = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [N-1:0] move_start,
  output logic [N-1:0] motion_busy
);
  int cnt [N];
  // one move per start pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < N; i++) begin
      if (!hresetn) begin
        cnt[i] <= 0;
      end else if (move_start[i]) begin
        cnt[i] <= MOVE_LEN;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < N; i++) begin
      motion_busy[i] = (cnt[i] != 0);
    end
  end
endmodule

// ===== test/axhh_core_tb.sv
// Purpose: self-checking bench for the axis home and hold block
// Assumes: zero wait state slave, single word transfers
// Notes: plant model supplies motion_busy
`timescale 1ns/1ps
module axhh_core_tb;
  import axhh_pkg::*;
  localparam int N = 4;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, irq;
  logic [N-1:0] home_pin = '1, index_pin = 0, enc_a_pin = 0, enc_b_pin = 0, motion_busy;
  logic [N-1:0][31:0] enc_pos = '0;
  logic [N-1:0] move_start, hold_enable, stall_enable, track_enable, loop_closed;
  logic [N-1:0] hold_dir, in_position, home_detect;
  logic [N-1:0][15:0] hold_vel;
  logic [15:0] move_ramp_up, move_ramp_down, last_up, last_dn;
  int n_fail = 0, checks = 0, n_starts = 0, cyc = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  axhh_core #(.N(N)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .home_pin(home_pin),
    .index_pin(index_pin), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin), .enc_pos(enc_pos),
    .motion_busy(motion_busy), .move_start(move_start), .move_ramp_up(move_ramp_up),
    .move_ramp_down(move_ramp_down), .hold_enable(hold_enable), .stall_enable(stall_enable),
    .track_enable(track_enable), .loop_closed(loop_closed), .hold_vel(hold_vel),
    .hold_dir(hold_dir), .in_position(in_position), .home_detect(home_detect), .irq(irq));
  axhh_plant #(.N(N), .MOVE_LEN(20)) plant (.hclk(hclk), .hresetn(hresetn),
    .move_start(move_start), .motion_busy(motion_busy));
  ////////////////////////////////////////////////////////////////////////////////
  // start capture and timeout
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (move_start != 0) begin
      n_starts <= n_starts + 1;
      last_up <= move_ramp_up;
      last_dn <= move_ramp_down;
    end
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  function automatic logic [11:0] ax(input int i, input logic [2:0] r);
    return AX_BASE + 12'(32 * i + 4 * int'(r));
  endfunction
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk("gain", ax(0, R_GAIN), 32'h1);
    rchk("deadband", ax(0, R_DB), 32'h0);
    rchk("home cfg", ax(1, R_HOME), 32'h6);
    bus(1'b0, ax(2, R_STAT), 32'h0);
    chk("status loops", 32'h0, rd & 32'hF0);
    chk("loop outs", 32'h0, {hold_enable, stall_enable, track_enable, loop_closed});
    chk("hresp", 32'h0, {31'h0, hresp});
    wr(12'h030, 32'h5);
    rchk("unmapped", 12'h030, 32'h0);
  endtask
  task automatic t_limits();
    wr(ax(1, R_DB), 32'd70000);
    rchk("db clamp", ax(1, R_DB), 32'd64000);
    wr(ax(1, R_GAIN), 32'd0);
    rchk("gain low", ax(1, R_GAIN), 32'd1);
    wr(ax(1, R_GAIN), 32'd40000);
    rchk("gain high", ax(1, R_GAIN), 32'd32000);
  endtask
  task automatic t_unequal();
    wr(A_MODE, 32'h0);
    wr(ax(0, R_RAMP), 32'h5678_1234);
    wr(A_CMD, 32'h3);
    wt(2);
    chk("starts", 32'd1, n_starts);
    chk("ramp up", 32'h1234, {16'h0, last_up});
    chk("ramp down", 32'h5678, {16'h0, last_dn});
    wt(25);
  endtask
  task automatic t_slip();
    wr(A_MODE, 32'h0);
    wr(A_IRQ_MSK, 32'h1);
    wr(A_CMD, 32'h1);
    wt(5);
    home_pin[0] <= 1'b0;
    wt(5);
    home_pin[0] <= 1'b1;
    wt(25);
    rchk("slip after go", A_IRQ_ST, 32'h0);
    wr(A_CMD, 32'h2);
    wt(5);
    home_pin[0] <= 1'b0;
    wt(5);
    home_pin[0] <= 1'b1;
    wt(25);
    rchk("slip flag", A_IRQ_ST, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    rchk("slip held", ax(0, R_STAT), 32'h3);
    wr(A_IRQ_ST, 32'h1);
    wt(2);
    rchk("slip clear", A_IRQ_ST, 32'h0);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask
  task automatic t_hold();
    wr(A_MODE, 32'h0);
    wr(ax(0, R_AXCFG), 32'h1);
    wr(ax(0, R_GAIN), 32'd3);
    wr(ax(0, R_DB), 32'd5);
    wr(ax(0, R_TGT), 32'd100);
    enc_pos[0] <= 32'd90;
    wr(A_CMD, 32'h4);
    wt(3);
    chk("hold on", 32'h7, {29'h0, hold_enable[0], stall_enable[0], track_enable[0]});
    chk("vel", 32'd30, {16'h0, hold_vel[0]});
    chk("dir up", 32'h0, {31'h0, hold_dir[0]});
    enc_pos[0] <= 32'd110;
    wr(ax(0, R_VLIM), 32'd20);
    wt(3);
    chk("vel lim", 32'd20, {16'h0, hold_vel[0]});
    chk("dir down", 32'h1, {31'h0, hold_dir[0]});
    wr(ax(0, R_DB), 32'd10);
    wt(3);
    chk("in pos", 32'h1, {31'h0, in_position[0]});
    chk("vel in pos", 32'h0, {16'h0, hold_vel[0]});
    rchk("report db", A_REPORT_DB, 32'd10);
    wr(ax(0, R_AXCFG), 32'hD);
    rchk("qcost enc", A_QCOST, 32'h030A);
    wr(A_MODE, 32'h1);
    rchk("qcost plain", A_QCOST, 32'h0005);
    wr(ax(2, R_AXCFG), 32'h2);
    wr(A_MODE, 32'h2);
    wr(A_CMD, 32'h4);
    wr(A_MODE, 32'h100);
    rchk("report multi", A_REPORT_DB, 32'h0);
    wr(A_CMD, 32'h0102);
    wr(A_CMD, 32'h0A05);
    wt(2);
    chk("hf null 0", 32'h1, {31'h0, hold_enable[0]});
    wr(A_CMD, 32'h0105);
    wt(3);
    chk("no multi slip", 32'd3, n_starts);
    chk("hf addressed", 32'h0, {29'h0, hold_enable[0], stall_enable[0], track_enable[0]});
    chk("hf null", 32'h1, {31'h0, loop_closed[2]});
    wr(A_MODE, 32'h2);
    wr(A_CMD, 32'h5);
    wt(3);
    chk("servo open", 32'h0, {31'h0, loop_closed[2]});
  endtask
  task automatic t_home();
    wr(A_MODE, 32'h3);
    home_pin[3] <= 1'b0;
    wt(5);
    chk("switch home", 32'h1, {31'h0, home_detect[3]});
    wr(A_CMD, 32'h6);
    wt(5);
    chk("enc no idx", 32'h0, {31'h0, home_detect[3]});
    chk("no motion", 32'd3, n_starts);
    index_pin[3] <= 1'b1;
    enc_a_pin[3] <= 1'b1;
    wt(5);
    chk("enc home", 32'h1, {31'h0, home_detect[3]});
    enc_b_pin[3] <= 1'b1;
    wt(5);
    chk("enc b high", 32'h0, {31'h0, home_detect[3]});
    wr(ax(3, R_HOME), 32'h1F);
    home_pin[3] <= 1'b1;
    wt(5);
    chk("pol all high", 32'h1, {31'h0, home_detect[3]});
    index_pin[3] <= 1'b0;
    wr(A_CMD, 32'h7);
    wt(5);
    chk("switch only", 32'h1, {31'h0, home_detect[3]});
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_limits();
    t_unequal();
    t_slip();
    t_hold();
    t_home();
    give_verdict();
  end
endmodule
